/* logic/ps_chain_source.sv */
// configuration source: drives n-bit passive serial targets from a software-fed word register
`timescale 1ns/1ps
`default_nettype none
module ps_chain_source #(
	parameter int max_width      = 8,
	parameter int release_wait   = ps_chain_pkg::release_wait_cyc,
	parameter int request_low    = ps_chain_pkg::request_low_cyc
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// data words from software side
	input  wire logic [max_width-1:0] word_i,
	input  wire logic        word_valid_i,
	output logic             word_ready_o,
	// target pins
	output logic             serial_data_clock_o,
	output logic [max_width-1:0] serial_data_o,
	output logic             config_request_n_o,
	output logic             status_n_o,
	output logic             status_n_oe_o,
	input  wire logic        status_n_i,
	input  wire logic        config_done_i
);
	// synchronisers for the wired lines
	logic [1:0] status_sync;
	logic [1:0] done_sync;
	// register file
	logic        ctrl_older;      // older source type chosen
	logic        ctrl_restart;    // automatic retry after error
	logic [3:0]  width;           // active data lines
	logic [31:0] length;          // bit count per line
	logic        start_pulse;     // one-cycle start from software
	logic        done_flag;
	logic        error_flag;
	// engine state
	ps_chain_pkg::state_type state;
	ps_chain_pkg::state_type next_state;
	logic [31:0] count;
	logic [31:0] next_count;
	logic [3:0]  divider;
	logic [3:0]  next_divider;
	logic        sclk;
	logic        next_sclk;
	logic [max_width-1:0] data;
	logic [max_width-1:0] next_data;
	logic        request_n;
	logic        next_request_n;
	logic        drive_low;
	logic        next_drive_low;
	logic        ready;
	logic        next_ready;
	logic        set_done;
	logic        set_error;
	// bus registers next values
	logic        next_ack;
	logic [31:0] next_dat;
	logic        next_older;
	logic        next_restart;
	logic [3:0]  next_width;
	logic [31:0] next_length;
	logic        next_start;
	logic        next_done_flag;
	logic        next_error_flag;
	logic        bus_write;
	logic [3:0]  width_mask;

	// joined complete and status lines sampled
	// synchronise pins; first stage read only by second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_sync <= 2'h3;
			done_sync   <= 2'h0;
		end else begin
			status_sync <= {status_sync[0], status_n_i};
			done_sync   <= {done_sync[0], config_done_i};
		end
	end

	// bus decode and register updates
	always_comb begin
		bus_write       = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
		next_ack        = cyc_i && stb_i && !ack_o;
		next_older      = ctrl_older;
		next_restart    = ctrl_restart;
		next_width      = width;
		next_length     = length;
		next_start      = 1'b0;
		next_done_flag  = done_flag;
		next_error_flag = error_flag;
		next_dat        = 32'h0000_0000;
		if (bus_write) begin
			case (adr_i)
				ps_chain_pkg::ctrl_offset: begin
					// source type only picks the completion wait
					next_start   = dat_i[ps_chain_pkg::ctrl_start_bit];
					next_older   = dat_i[ps_chain_pkg::ctrl_older_bit];
					next_restart = dat_i[ps_chain_pkg::ctrl_restart_bit];
				end
				ps_chain_pkg::status_offset: begin
					// write one clears the flags
					if (dat_i[ps_chain_pkg::stat_done_bit]) next_done_flag = 1'b0;
					if (dat_i[ps_chain_pkg::stat_error_bit]) next_error_flag = 1'b0;
				end
				ps_chain_pkg::width_offset: begin
					if (dat_i[3:0] == 4'h1 || dat_i[3:0] == 4'h2 || dat_i[3:0] == 4'h4 || dat_i[3:0] == 4'h8)
						next_width = dat_i[3:0];
				end
				// bits per line, longer for chains
				ps_chain_pkg::length_offset: next_length = dat_i;
				default: ;
			endcase
		end
		// hardware set wins over clear
		if (set_done) next_done_flag = 1'b1;
		if (set_error) next_error_flag = 1'b1;
		if (next_ack && !we_i) begin
			case (adr_i)
				ps_chain_pkg::ctrl_offset: begin
					next_dat[ps_chain_pkg::ctrl_older_bit]   = ctrl_older;
					next_dat[ps_chain_pkg::ctrl_restart_bit] = ctrl_restart;
				end
				ps_chain_pkg::status_offset: begin
					next_dat[ps_chain_pkg::stat_busy_bit]  = (state != ps_chain_pkg::st_idle);
					next_dat[ps_chain_pkg::stat_done_bit]  = done_flag;
					next_dat[ps_chain_pkg::stat_error_bit] = error_flag;
					next_dat[ps_chain_pkg::stat_state_lsb +: 3] = state;
				end
				ps_chain_pkg::width_offset:  next_dat[3:0] = width;
				ps_chain_pkg::length_offset: next_dat = length;
				default: next_dat = 32'h0000_0000;
			endcase
		end
	end

	// register the bus side
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o        <= 1'b0;
			dat_o        <= 32'h0000_0000;
			ctrl_older   <= 1'b0;
			ctrl_restart <= 1'b0;
			width        <= ps_chain_pkg::width_reset;
			length       <= ps_chain_pkg::length_reset;
			start_pulse  <= 1'b0;
			done_flag    <= 1'b0;
			error_flag   <= 1'b0;
		end else begin
			ack_o        <= next_ack;
			dat_o        <= next_dat;
			ctrl_older   <= next_older;
			ctrl_restart <= next_restart;
			width        <= next_width;
			length       <= next_length;
			start_pulse  <= next_start;
			done_flag    <= next_done_flag;
			error_flag   <= next_error_flag;
		end
	end

	// engine: request pulse, shift, completion wait, failure
	always_comb begin
		next_state     = state;
		next_count     = count;
		next_divider   = divider;
		next_sclk      = sclk;
		next_data      = data;
		next_request_n = request_n;
		next_drive_low = drive_low;
		next_ready     = 1'b0;
		set_done       = 1'b0;
		set_error      = 1'b0;
		width_mask     = width - 4'h1;
		case (state)
			ps_chain_pkg::st_idle: begin
				next_sclk = 1'b0;
				if (start_pulse) begin
					next_state     = ps_chain_pkg::st_request;
					next_request_n = 1'b0;
					next_count     = 32'h0;
				end
			end
			ps_chain_pkg::st_request: begin
				next_count = count + 32'h1;
				if (count >= 32'(request_low)) begin
					next_request_n = 1'b1;
					next_count     = 32'h0;
					next_state     = ps_chain_pkg::st_wait_status;
				end
			end
			ps_chain_pkg::st_wait_status: begin
				next_count = count + 32'h1;
				if (status_sync[1]) begin
					next_count   = 32'h0;
					next_divider = 4'h0;
					next_state   = ps_chain_pkg::st_shift;
				end else if (count >= 32'(release_wait)) begin
					set_error  = 1'b1;
					next_state = ps_chain_pkg::st_fail;
				end
			end
			ps_chain_pkg::st_shift: begin
				next_divider = divider + 4'h1;
				if (!status_sync[1]) begin
					set_error  = 1'b1;
					next_sclk  = 1'b0;
					next_state = ps_chain_pkg::st_fail;
				end else if (divider == ps_chain_pkg::half_period) begin
					next_divider = 4'h0;
					if (!sclk && count != 32'h0) begin
						// rising edge: data already stable
						next_sclk = 1'b1;
					end else begin
						// first word loads with the clock still low, so no stale bit is clocked in
						next_sclk = 1'b0;
						if (count == length) begin
							next_count = 32'h0;
							next_state = ps_chain_pkg::st_wait_done;
						end else if (word_valid_i) begin
							// next word follows at once, no gap
							next_data  = word_i & max_width'((1 << (width_mask + 4'h1)) - 1);
							next_ready = 1'b1;
							next_count = count + 32'h1;
						end
					end
				end
			end
			// complete within 64 or 16 clocks
			ps_chain_pkg::st_wait_done: begin
				next_divider = divider + 4'h1;
				if (done_sync[1]) begin
					set_done   = 1'b1;
					next_sclk  = 1'b0;
					next_state = ps_chain_pkg::st_done;
				end else if (divider == ps_chain_pkg::half_period) begin
					next_divider = 4'h0;
					next_sclk    = !sclk;
					if (!sclk) begin
						// each rise here closes one clock period after the last bit's rise
						next_count = count + 32'h1;
						if (count[6:0] == (ctrl_older ? ps_chain_pkg::wait_older : ps_chain_pkg::wait_enhanced) - 7'h1) begin
							// pull status low in st_fail unless ctrl_restart is set; the closing rise is not driven
							set_error      = 1'b1;
							next_sclk      = 1'b0;
							next_state     = ps_chain_pkg::st_fail;
						end
					end
				end
			end
			ps_chain_pkg::st_fail: begin
				next_drive_low = 1'b1;
				next_sclk      = 1'b0;
				if (start_pulse || ctrl_restart) begin
					next_drive_low = 1'b0;
					next_count     = 32'h0;
					next_state     = ps_chain_pkg::st_wait_status;
				end
			end
			ps_chain_pkg::st_done: begin
				next_state = ps_chain_pkg::st_idle;
			end
			default: next_state = ps_chain_pkg::st_idle;
		endcase
	end

	// register the engine; outputs all from flops except status_n_o, which is tied low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state     <= ps_chain_pkg::st_idle;
			count     <= 32'h0;
			divider   <= 4'h0;
			sclk      <= 1'b0;
			data      <= '0;
			request_n <= 1'b1;
			drive_low <= 1'b0;
			ready     <= 1'b0;
		end else begin
			state     <= next_state;
			count     <= next_count;
			divider   <= next_divider;
			sclk      <= next_sclk;
			data      <= next_data;
			request_n <= next_request_n;
			drive_low <= next_drive_low;
			ready     <= next_ready;
		end
	end

	assign status_n_o          = 1'b0;
	assign status_n_oe_o       = drive_low;
	// one clock and data set shared by all targets
	assign serial_data_clock_o = sclk;
	assign serial_data_o       = data;
	// single request output for the chain
	assign config_request_n_o  = request_n;
	assign word_ready_o        = ready;
endmodule
`default_nettype wire

/* logic/ps_chain_pkg.sv */
// package for the multi-target passive serial configuration source
// Summary of operation
// - Source offers widths of 1, 2, 4, 8
// - Width matches target count for speed
// - Surplus data lines carry nothing, unconnected
// - One line may feed two chained targets
// - Broadcast targets share every line, enable low
// - Master source generates the data clock
// - Chip select from config-complete, cascade chained
// - Cascade handover completes within one clock
// - Enhanced sources are never cascaded
// - Any error halts and restarts whole chain
// - Missing config-complete drives status low; with ctrl_restart set the source retries without pulling it
// - Init trigger may drive configuration request
// - Only first source drives configuration request
// - Mixed chains join complete and status lines
// - Wait 64 or 16 clocks for complete
// - Retry once status released after timeout
package ps_chain_pkg;
	// register offsets of the controller's own register file
	localparam logic [3:0] ctrl_offset    = 4'h0;
	localparam logic [3:0] status_offset  = 4'h4;
	localparam logic [3:0] width_offset   = 4'h8;
	localparam logic [3:0] length_offset  = 4'hC;
	// control field positions
	localparam int ctrl_start_bit   = 0;
	localparam int ctrl_older_bit   = 1;
	localparam int ctrl_restart_bit = 2;
	localparam int ctrl_trigger_bit = 3;
	// status field positions
	localparam int stat_busy_bit  = 0;
	localparam int stat_done_bit  = 1;
	localparam int stat_error_bit = 2;
	localparam int stat_state_lsb = 4;
	// reset values
	localparam logic [3:0]  width_reset  = 4'h1;
	localparam logic [31:0] length_reset = 32'h0000_0100;
	// completion waits after last bit
	localparam logic [6:0] wait_enhanced = 7'h40;
	localparam logic [6:0] wait_older    = 7'h10;
	// data clock divider half period less one, in system clocks
	localparam logic [3:0] half_period = 4'h6;
	// least low time of the request pulse
	localparam int request_low_us  = 2;
	localparam int clock_mhz       = 250;
	localparam int request_low_cyc = request_low_us * clock_mhz;
	// retry wait for released status
	localparam int release_wait_us  = 100;
	localparam int release_wait_cyc = release_wait_us * clock_mhz;
	// controller states
	typedef enum logic [2:0] {
		st_idle,
		st_request,
		st_wait_status,
		st_shift,
		st_wait_done,
		st_fail,
		st_done
	} state_type;
endpackage

/* bench/ps_chain_chk.sv */
// bound checker for the chain configuration source
`timescale 1ns/1ps
`default_nettype none
module ps_chain_chk #(
	parameter int max_width   = 8,
	parameter int request_low = 4
) (
	// clock and reset
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	// target side
	input wire logic                 word_ready_o,
	input wire logic                 serial_data_clock_o,
	input wire logic [max_width-1:0] serial_data_o,
	input wire logic                 config_request_n_o,
	input wire logic                 status_n_o,
	input wire logic                 status_n_oe_o,
	input wire logic                 status_n_i,
	input wire logic                 config_done_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// long low times are counted, not unrolled
	int low_cnt;
	int next_low_cnt;
	always_comb next_low_cnt = config_request_n_o ? 0 : low_cnt + 1;
	always_ff @(posedge clk_i) low_cnt <= next_low_cnt;
	AST_DRAIN: assert property (status_n_oe_o |-> !status_n_o && !serial_data_clock_o && !word_ready_o) else $error("pull while shifting");
	AST_DATA_LOW: assert property ($changed(serial_data_o) |-> !serial_data_clock_o) else $error("data moved");
	AST_READY_LOW: assert property (word_ready_o |-> !serial_data_clock_o) else $error("word late");
	AST_READY_GAP: assert property (word_ready_o |=> !word_ready_o [*8]) else $error("words close");
	AST_REQ_LEN: assert property ($rose(config_request_n_o) |-> low_cnt >= request_low) else $error("short");
	AST_REQ_QUIET: assert property (!config_request_n_o |-> !word_ready_o) else $error("word in request");
	AST_HELD: assert property (!status_n_i [*6] |-> !word_ready_o) else $error("word in reset");
	AST_DONE_QUIET: assert property (config_done_i [*4] |-> !$rose(status_n_oe_o)) else $error("pull");
	C_FAIL: cover property ($rose(status_n_oe_o));
	C_REQ: cover property ($fell(config_request_n_o));
	C_WORDS: cover property (word_ready_o ##14 word_ready_o);
endmodule
bind ps_chain_source ps_chain_chk #(.max_width(max_width), .request_low(request_low)) chk (.clk_i, .rst_i,
	.word_ready_o, .serial_data_clock_o, .serial_data_o, .config_request_n_o, .status_n_o, .status_n_oe_o,
	.status_n_i, .config_done_i);
`default_nettype wire

/* bench/ps_target_chain.sv */
// behavioural target chain on the shared configuration lines
`timescale 1ns/1ps
`default_nettype none
module ps_target_chain #(
	parameter int reset_wait = 10,
	parameter int need       = 8
) (
	// clock and reset
	input wire logic       clk_i,
	input wire logic       rst_i,
	// lines from the source, lines in use, fault kind
	input wire logic       serial_data_clock_i,
	input wire logic [7:0] data_i,
	input wire logic       request_n_i,
	input wire logic       line_n_i,
	input wire logic [7:0] mask_i,
	input wire logic [1:0] fault_i,
	// status pull, complete line, hash of data taken
	output logic           low_o,
	output logic           done_o,
	output logic [31:0]    hash_o
);
	logic serial_data_clock_q;
	int   bits;
	int   hold;
	always_ff @(posedge clk_i) begin
		serial_data_clock_q <= serial_data_clock_i;
		if (rst_i || !request_n_i || (!line_n_i && !low_o) || (fault_i == 2'd2 && bits == 2)) begin
			hold <= reset_wait;
			low_o <= 1'b1;
			bits <= 0;
			hash_o <= '0;
			done_o <= 1'b0;
		end else if (hold > 0) begin
			hold <= hold - 1;
			low_o <= hold > 1;
		end else if (serial_data_clock_i && !serial_data_clock_q && !done_o) begin
			bits <= bits + 1;
			hash_o <= {hash_o[30:0], hash_o[31]} ^ (data_i & mask_i);
			done_o <= bits == need - 1 && fault_i != 2'd1;
		end
	end
endmodule
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the chain configuration source
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, word_valid_i, word_ready_o, serial_data_clock_o;
	logic        config_request_n_o, status_n_o, status_n_oe_o, model_low, config_done_i, oe_q;
	logic [3:0]  adr_i, sel_i;
	logic [7:0]  word_i, serial_data_o, mask;
	logic [31:0] dat_i, dat_o, q, hash, ref_hash;
	logic [1:0]  fault;
	int          seed, miscompares, checks_done, cyc_n, last_rdy, oe_at, p;
	wire logic   status_n_i;
	assign status_n_i = !(status_n_oe_o && !status_n_o) && !model_low;
	ps_chain_source #(.max_width(8), .release_wait(40), .request_low(4)) dut (.clk_i, .rst_i, .cyc_i, .stb_i,
		.we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .word_i, .word_valid_i, .word_ready_o,
		.serial_data_clock_o, .serial_data_o, .config_request_n_o, .status_n_o, .status_n_oe_o, .status_n_i,
		.config_done_i);
	ps_target_chain #(.reset_wait(10), .need(8)) chain (.clk_i, .rst_i, .serial_data_clock_i(serial_data_clock_o),
		.data_i(serial_data_o), .request_n_i(config_request_n_o), .line_n_i(status_n_i), .mask_i(mask),
		.fault_i(fault), .low_o(model_low), .done_o(config_done_i), .hash_o(hash));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// reference hash of words taken; cleared while targets sit in reset
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		oe_q <= status_n_oe_o;
		if (status_n_oe_o === 1'b1 && oe_q === 1'b0)
			oe_at <= cyc_n;
		if (status_n_i === 1'b0)
			ref_hash <= '0;
		else if (word_ready_o === 1'b1) begin
			ref_hash <= {ref_hash[30:0], ref_hash[31]} ^ (word_i & mask);
			chk(32'(serial_data_o), 32'(word_i & mask));
			last_rdy <= cyc_n;
			word_i <= $random(seed);
		end
	end
	// one classic cycle; waits for ack, the watchdog ends a hang
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		{cyc_i, stb_i} <= 2'b00;
		@(posedge clk_i);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			miscompares++;
			$display("BAD t=%0t got=%h want=%h", $time, got, want);
		end
	endtask
	// start a run and poll until complete or error
	task automatic start(input logic [31:0] ctl, input logic [1:0] f);
		fault <= f;
		word_valid_i <= 1'b1;
		// stale flags from an earlier run must not end the poll early
		wb(1'b1, ps_chain_pkg::status_offset,
			(32'h1 << ps_chain_pkg::stat_done_bit) | (32'h1 << ps_chain_pkg::stat_error_bit));
		wb(1'b1, ps_chain_pkg::ctrl_offset, ctl);
		repeat (8) @(posedge clk_i);
		do wb(1'b0, ps_chain_pkg::status_offset, '0);
		while (!(config_done_i === 1'b1 && q[ps_chain_pkg::stat_done_bit] === 1'b1) && q[2] !== 1'b1);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		{rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, word_i, word_valid_i, fault, ref_hash} = {1'b1, 82'h0};
		{sel_i, mask, seed, oe_q, cyc_n, last_rdy, oe_at, miscompares, checks_done} = {12'hF01, 32'd38427, 161'h0};
		p = 2 * (ps_chain_pkg::half_period + 1);
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, ps_chain_pkg::length_offset, '0);
		chk(q, ps_chain_pkg::length_reset);
		wb(1'b0, ps_chain_pkg::status_offset, '0);
		chk(q, 32'h0);
		wb(1'b0, 4'h2, '0);
		chk(q, 32'h0);
		wb(1'b1, ps_chain_pkg::width_offset, 32'h3);
		wb(1'b0, ps_chain_pkg::width_offset, '0);
		chk(q, 32'(ps_chain_pkg::width_reset));
		wb(1'b1, ps_chain_pkg::length_offset, 32'h8);
		// every offered width, random wait kind
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, ps_chain_pkg::width_offset, 32'h1 << i);
			wb(1'b0, ps_chain_pkg::width_offset, '0);
			chk(q, 32'h1 << i);
			mask <= 8'hFF >> (8 - (1 << i));
			start(32'h1 | 32'(($random(seed) & 1) << ps_chain_pkg::ctrl_older_bit), 2'd0);
			chk(hash, ref_hash);
		end
		// chain never completes: older then enhanced wait
		for (int i = 0; i < 2; i++) begin
			wb(1'b1, ps_chain_pkg::status_offset, 32'h1 << ps_chain_pkg::stat_error_bit);
			start(i ? 32'h1 : 32'h3, 2'd1);
			chk(q[ps_chain_pkg::stat_error_bit], 1'b1);
			chk(32'(oe_at - last_rdy) / p, i ? 32'd64 : 32'd16);
		end
		// error mid-stream, automatic retry
		wb(1'b1, ps_chain_pkg::status_offset, 32'h1 << ps_chain_pkg::stat_error_bit);
		start(32'h5, 2'd2);
		chk(q[ps_chain_pkg::stat_error_bit], 1'b1);
		fault <= 2'd0;
		wb(1'b1, ps_chain_pkg::status_offset, 32'h1 << ps_chain_pkg::stat_error_bit);
		start(32'h4, 2'd0);
		chk(hash, ref_hash);
		chk(q[ps_chain_pkg::stat_error_bit], 1'b0);
		conclude();
	end
	// watchdog, far beyond the longest run
	initial begin
		#80000;
		miscompares++;
		conclude();
	end
endmodule
`default_nettype wire
